//--- inc/dvf_regs.svh
// Purpose: Constants for the DV formatter control register bank.
// Assumes: Classic Wishbone, 32-bit data, 50 MHz clk_i.
// Notes:   Only bits 10 to 31 of the control word are held here.
`ifndef DVF_REGS_SVH
`define DVF_REGS_SVH
`define DVF_CTRL_OFS     8'hf0
`define DVF_RXFIFO_OFS   8'hf4
`define DVF_TXFIFO_OFS   8'hf8
`define DVF_STAT_OFS     8'hfc
`define DVF_B_RELEASE    10
`define DVF_B_TSINS      11
`define DVF_B_VSTD       12
`define DVF_B_STRIP      16
`define DVF_B_MODE_LO    18
`define DVF_B_RXDST      24
`define DVF_B_TXSRC      25
`define DVF_B_RXFL       26
`define DVF_B_TXFL       27
`define DVF_B_SUB        28
`define DVF_B_HDRINS     31
`define DVF_CTRL_RESET   32'h0000_1000
`define DVF_CTRL_RWMASK  32'h930d_1c00
`endif

//--- inc/dvf_pkg.sv
// Purpose: Types for the DV formatter control bank.
// Assumes: Nothing.
// Notes:   Mode code zero is DV.
package dvf_pkg;
  typedef enum logic [1:0] {
    MODE_DV,
    MODE_ONE,
    MODE_TWO,
    MODE_THREE
  } op_mode_t;
  typedef enum {
    GATE_IDLE,
    GATE_OUT_SEEN,
    GATE_OPEN
  } gate_state_t;
endpackage

//--- logic/dv_formatter_control.sv
// Purpose: DV formatter control word, FIFO path selection and read gating.
// Assumes: Classic Wishbone slave, one-wait-state ack; strobes synchronous.
// Notes:   FIFOs are two-entry buffers; framing logic lies outside this bank.
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "dvf_regs.svh"
module dv_formatter_control
  import dvf_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [31:0] rx_data_i,
  input  wire logic        rx_valid_i,
  output logic             rx_ready_o,
  input  wire logic        output_frame_strobe_i,
  input  wire logic        input_frame_strobe_i,
  input  wire logic        bulk_output_enable_i,
  output logic      [31:0] port_rd_data_o,
  output logic             port_rd_valid_o,
  input  wire logic [31:0] port_wr_data_i,
  input  wire logic        port_wr_valid_i,
  output logic             port_wr_ready_o,
  output logic      [31:0] tx_data_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  output logic             video_standard_select_o,
  output logic             timestamp_insert_enable_o,
  output logic             receive_header_strip_o,
  output logic             transmit_header_insert_o,
  output logic             video_sub_mode_o,
  output logic [1:0]       mode_code_o,
  output logic             dv_mode_o
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [31:0]   ctrl_ff;
  logic [31:0]   wmask;
  logic          req;
  logic          wr_ctrl;
  logic          host_rx_pop;
  logic          host_tx_push;
  logic          rx_flush_ff;
  logic          tx_flush_ff;
  logic [31:0]   rx_q [2];
  logic [1:0]    rx_cnt_ff;
  logic          rx_rp_ff;
  logic          rx_wp_ff;
  logic [1:0]    nxt_rx_cnt;
  logic [31:0]   tx_q [2];
  logic [1:0]    tx_cnt_ff;
  logic          tx_rp_ff;
  logic          tx_wp_ff;
  gate_state_t   gate_ff;
  logic          gate_open;
  logic          rx_push;
  logic          rx_pop;
  logic          tx_push;
  logic          tx_pop;
  logic          port_pop;
  logic          rx_dst;
  logic          tx_src;
  logic [31:0]   tx_in;

  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  assign req          = cyc_i && stb_i && !ack_o;
  assign wmask        = lane_mask(sel_i) & `DVF_CTRL_RWMASK;
  assign wr_ctrl      = req && we_i && adr_i == `DVF_CTRL_OFS;
  assign rx_dst       = ctrl_ff[`DVF_B_RXDST];
  assign tx_src       = ctrl_ff[`DVF_B_TXSRC];
  assign host_rx_pop  = req && !we_i && adr_i == `DVF_RXFIFO_OFS && !rx_dst;
  assign host_tx_push = req && we_i && adr_i == `DVF_TXFIFO_OFS && !tx_src;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // ----------------------------------------
  // Control word
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `DVF_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= (ctrl_ff & ~wmask) | (dat_i & wmask);
    end
  end

  // Flush pulses last one cycle; the bits lie outside the writable mask, so they never read back as set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_flush_ff <= 1'b0;
      tx_flush_ff <= 1'b0;
    end else begin
      rx_flush_ff <= wr_ctrl && sel_i[3] && dat_i[`DVF_B_RXFL];
      tx_flush_ff <= wr_ctrl && sel_i[3] && dat_i[`DVF_B_TXFL];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      video_standard_select_o   <= 1'b1;
      timestamp_insert_enable_o <= 1'b0;
      receive_header_strip_o    <= 1'b0;
      transmit_header_insert_o  <= 1'b0;
      video_sub_mode_o          <= 1'b0;
      mode_code_o               <= 2'h0;
      dv_mode_o                 <= 1'b1;
    end else begin
      video_standard_select_o   <= ctrl_ff[`DVF_B_VSTD];
      timestamp_insert_enable_o <= ctrl_ff[`DVF_B_TSINS];
      receive_header_strip_o    <= ctrl_ff[`DVF_B_STRIP];
      transmit_header_insert_o  <= ctrl_ff[`DVF_B_HDRINS];
      video_sub_mode_o          <= ctrl_ff[`DVF_B_SUB];
      mode_code_o               <= ctrl_ff[`DVF_B_MODE_LO +: 2];
      dv_mode_o                 <= op_mode_t'(ctrl_ff[`DVF_B_MODE_LO +: 2]) == MODE_DV;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (req && !we_i) begin
      case (adr_i)
        `DVF_CTRL_OFS:   dat_o <= ctrl_ff & `DVF_CTRL_RWMASK;
        `DVF_RXFIFO_OFS: dat_o <= (!rx_dst && rx_cnt_ff != 2'h0) ? rx_q[rx_rp_ff] : 32'h0;
        `DVF_STAT_OFS:   dat_o <= {26'h0, gate_open, tx_cnt_ff, rx_cnt_ff, rx_dst};
        default:         dat_o <= 32'h0;
      endcase
    end else begin
      dat_o <= 32'h0;
    end
  end

  // ----------------------------------------
  // Receive buffer
  // ----------------------------------------
  // Sub-mode 1 keeps only headers in registers outside, so nothing is queued
  assign rx_push    = rx_valid_i && rx_ready_o && rx_cnt_ff != 2'h2 && !video_sub_mode_o;
  assign port_pop   = rx_dst && gate_open && bulk_output_enable_i && rx_cnt_ff != 2'h0;
  assign rx_pop     = rx_cnt_ff != 2'h0 && (host_rx_pop || port_pop);
  assign nxt_rx_cnt = rx_flush_ff ? 2'h0 : rx_cnt_ff + {1'b0, rx_push} - {1'b0, rx_pop};

  // Ready looks one count ahead so it can stay a flop without overfilling
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_ready_o <= 1'b1;
    end else begin
      rx_ready_o <= nxt_rx_cnt != 2'h2 || ctrl_ff[`DVF_B_SUB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_flush_ff) begin
      rx_cnt_ff <= 2'h0;
      rx_rp_ff  <= 1'b0;
      rx_wp_ff  <= 1'b0;
    end else begin
      rx_cnt_ff <= rx_cnt_ff + {1'b0, rx_push} - {1'b0, rx_pop};
      rx_rp_ff  <= rx_rp_ff ^ rx_pop;
      rx_wp_ff  <= rx_wp_ff ^ rx_push;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rx_push) begin
      rx_q[rx_wp_ff] <= rx_data_i;
    end
  end

  // ----------------------------------------
  // Gated release toward the port
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_ff <= GATE_IDLE;
    end else begin
      case (gate_ff)
        GATE_IDLE:     if (output_frame_strobe_i) gate_ff <= GATE_OUT_SEEN;
        GATE_OUT_SEEN: if (input_frame_strobe_i) gate_ff <= GATE_OPEN;
        GATE_OPEN:     if (!bulk_output_enable_i && output_frame_strobe_i) begin
          gate_ff <= GATE_OUT_SEEN;
        end
        default:       gate_ff <= GATE_IDLE;
      endcase
    end
  end

  assign gate_open = !(ctrl_ff[`DVF_B_RELEASE] && dv_mode_o) || gate_ff == GATE_OPEN;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_rd_valid_o <= 1'b0;
      port_rd_data_o  <= 32'h0;
    end else begin
      port_rd_valid_o <= port_pop;
      port_rd_data_o  <= port_pop ? rx_q[rx_rp_ff] : 32'h0;
    end
  end

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  // Sub-mode 1 sends empty packets only, so payload is not accepted
  assign tx_in   = tx_src ? port_wr_data_i : dat_i;
  assign tx_push = tx_cnt_ff != 2'h2 && !video_sub_mode_o
                   && (tx_src ? port_wr_valid_i && port_wr_ready_o : host_tx_push);
  assign tx_pop  = tx_valid_o && tx_ready_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_wr_ready_o <= 1'b0;
    end else begin
      port_wr_ready_o <= tx_src && !video_sub_mode_o && tx_cnt_ff == 2'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || tx_flush_ff) begin
      tx_cnt_ff <= 2'h0;
      tx_rp_ff  <= 1'b0;
      tx_wp_ff  <= 1'b0;
    end else begin
      tx_cnt_ff <= tx_cnt_ff + {1'b0, tx_push} - {1'b0, tx_pop};
      tx_rp_ff  <= tx_rp_ff ^ tx_pop;
      tx_wp_ff  <= tx_wp_ff ^ tx_push;
    end
  end

  always_ff @(posedge clk_i) begin
    if (tx_push) begin
      tx_q[tx_wp_ff] <= tx_in;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || tx_flush_ff) begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= 32'h0;
    end else if (!tx_valid_o || tx_ready_i) begin
      tx_valid_o <= tx_cnt_ff > {1'b0, tx_pop};
      tx_data_o  <= tx_q[tx_rp_ff ^ tx_pop];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  reset_value_a: assert property (@(posedge clk_i) $fell(rst_i) |->
    ctrl_ff == `DVF_CTRL_RESET) else $error("Control word reset value wrong");
  std_reset_a: assert property (@(posedge clk_i) rst_i |=> video_standard_select_o)
    else $error("Video standard not NTSC after reset");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_ff & ~`DVF_CTRL_RWMASK) == 32'h0) else $error("Reserved bit set");
  rx_flush_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && sel_i[3] && dat_i[`DVF_B_RXFL] |=> ##1 rx_cnt_ff == 2'h0 && !rx_flush_ff)
    else $error("Receive flush failed");
  tx_flush_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && sel_i[3] && dat_i[`DVF_B_TXFL] |=> ##1 tx_cnt_ff == 2'h0 && !tx_flush_ff)
    else $error("Transmit flush failed");
  port_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    port_rd_valid_o |-> $past(rx_dst) && $past(bulk_output_enable_i))
    else $error("Port read without destination or enable");
  release_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_ff[`DVF_B_RELEASE] && rx_dst && bulk_output_enable_i && rx_cnt_ff != 2'h0
    |=> port_rd_valid_o) else $error("Ungated read not released");
  release_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_ff[`DVF_B_RELEASE] && dv_mode_o && gate_ff == GATE_IDLE |-> !port_pop)
    else $error("Gated read before strobes");
  host_rx_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_dst && req && !we_i && adr_i == `DVF_RXFIFO_OFS |=> dat_o == 32'h0)
    else $error("Host read of port FIFO returned data");
  host_tx_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !tx_src && port_wr_valid_i && !host_tx_push |=> tx_cnt_ff <= $past(tx_cnt_ff))
    else $error("Port write accepted with host source");
  dv_decode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 dv_mode_o == ($past(ctrl_ff[`DVF_B_MODE_LO +: 2]) == 2'h0))
    else $error("Mode decode wrong");
  vstd_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 video_standard_select_o == $past(ctrl_ff[`DVF_B_VSTD]))
    else $error("Video standard output does not follow control");
  rx_sub_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    video_sub_mode_o |=> rx_cnt_ff <= $past(rx_cnt_ff))
    else $error("Receive FIFO grew in header-only sub-mode");
  tx_sub_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    video_sub_mode_o |=> tx_cnt_ff <= $past(tx_cnt_ff))
    else $error("Transmit FIFO grew in empty-packet sub-mode");
  port_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_src && port_wr_valid_i && port_wr_ready_o && !video_sub_mode_o
    && tx_cnt_ff == 2'h0 && !tx_flush_ff |=> tx_cnt_ff == 2'h1)
    else $error("Port write not taken with port source");
endmodule

//--- tb/app_model.sv
// Purpose: Application logic on the bulky data port.
// Assumes: Signals change only just after rising edges.
// Notes:   Released write data shows the inverted last word.
`timescale 1ns/1ps
module app_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] port_rd_data_i,
  input  wire logic        port_rd_valid_i,
  input  wire logic        port_wr_ready_i,
  output logic             output_frame_strobe_o,
  output logic             input_frame_strobe_o,
  output logic             bulk_output_enable_o,
  output logic      [31:0] port_wr_data_o,
  output logic             port_wr_valid_o
);
  // ----------------------------------------
  // Read and write sequences
  // ----------------------------------------
  initial begin
    output_frame_strobe_o = 1'b0;
    input_frame_strobe_o = 1'b0;
    bulk_output_enable_o = 1'b0;
    port_wr_data_o = 32'h0;
    port_wr_valid_o = 1'b0;
  end
  // Enable held one cycle so that at most one word pops
  task automatic read_word(input logic seq, output logic got, output logic [31:0] d);
    got = 1'b0;
    d = 32'h0;
    if (seq) begin
      @(posedge clk_i) output_frame_strobe_o <= 1'b1;
      @(posedge clk_i) input_frame_strobe_o <= 1'b1;
    end
    @(posedge clk_i) bulk_output_enable_o <= 1'b1;
    @(posedge clk_i) bulk_output_enable_o <= 1'b0;
    repeat (4) begin
      @(posedge clk_i);
      if (port_rd_valid_i === 1'b1 && !got) begin
        got = 1'b1;
        d = port_rd_data_i;
      end
    end
    output_frame_strobe_o <= 1'b0;
    input_frame_strobe_o <= 1'b0;
  endtask
  task automatic write_word(input logic [31:0] d);
    logic took;
    took = 1'b0;
    @(posedge clk_i) begin
      port_wr_valid_o <= 1'b1;
      port_wr_data_o <= d;
    end
    repeat (8) if (!took) begin
      @(posedge clk_i);
      took = (port_wr_ready_i === 1'b1);
    end
    port_wr_valid_o <= 1'b0;
    port_wr_data_o <= ~d;
  endtask
endmodule

//--- tb/dv_formatter_control_tb_top.sv
// Purpose: Self-checking bench for the DV formatter control bank.
// Assumes: Wishbone ack one cycle after the request is taken.
// Notes:   Expected control mask follows the writable control bits.
`timescale 1ns/1ps
`include "dvf_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module dv_formatter_control_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, rx_valid = 1'b0, tx_ready = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rx_data = 32'h0, q, rd, dat_o, prd, pwd, txd;
  logic        ack, rxr, ofs, ifs, boe, prv, pwv, pwr, txv, vss, tse, rhs, thi, vsm, dvm, got;
  logic [1:0]  mode;
  int          fail_count = 0, check_count = 0;
  always #10 clk_i = ~clk_i;
  dv_formatter_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack),
    .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rxr),
    .output_frame_strobe_i(ofs), .input_frame_strobe_i(ifs), .bulk_output_enable_i(boe),
    .port_rd_data_o(prd), .port_rd_valid_o(prv), .port_wr_data_i(pwd),
    .port_wr_valid_i(pwv), .port_wr_ready_o(pwr), .tx_data_o(txd), .tx_valid_o(txv),
    .tx_ready_i(tx_ready), .video_standard_select_o(vss), .timestamp_insert_enable_o(tse),
    .receive_header_strip_o(rhs), .transmit_header_insert_o(thi), .video_sub_mode_o(vsm),
    .mode_code_o(mode), .dv_mode_o(dvm));
  app_model app_u (.clk_i(clk_i), .port_rd_data_i(prd), .port_rd_valid_i(prv),
    .port_wr_ready_i(pwr), .output_frame_strobe_o(ofs), .input_frame_strobe_o(ifs),
    .bulk_output_enable_o(boe), .port_wr_data_o(pwd), .port_wr_valid_o(pwv));
  // ----------------------------------------
  // Bus and stream tasks
  // ----------------------------------------
  task automatic conclude();
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i) begin
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    end
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0; wdat <= ~d;
  endtask
  task automatic push_rx(input logic [31:0] d);
    @(posedge clk_i) begin
      rx_valid <= 1'b1; rx_data <= d;
    end
    do @(posedge clk_i); while (rxr !== 1'b1);
    rx_valid <= 1'b0; rx_data <= ~d;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `DVF_CTRL_OFS, 0); `CHK(q, 32'h0000_1000)
    `CHK({vss, dvm, mode}, 4'b1100)
    wb(1, `DVF_CTRL_OFS, 32'hffff_ffff); wb(0, `DVF_CTRL_OFS, 0);
    `CHK(q, 32'h930d_1c00)
    `CHK(tse, 1'b1)
    `CHK(rhs, 1'b1)
    `CHK(thi, 1'b1)
    `CHK(vsm, 1'b1)
    for (int m = 0; m < 4; m++) begin
      wb(1, `DVF_CTRL_OFS, {12'h0, m[1:0], 18'h0});
      @(negedge clk_i);
      `CHK({mode, dvm}, {m[1:0], m == 0})
    end
    `CHK(vss, 1'b0)
    wb(0, 8'h04, 0); `CHK(q, 32'h0)
    push_rx(32'h1111_0001); push_rx(32'h1111_0002); @(posedge clk_i);
    `CHK(rxr, 1'b0)
    app_u.read_word(0, got, rd); `CHK(got, 1'b0)
    wb(0, `DVF_RXFIFO_OFS, 0); `CHK(q, 32'h1111_0001)
    wb(0, `DVF_RXFIFO_OFS, 0); `CHK(q, 32'h1111_0002)
    push_rx(32'h1111_0003); wb(1, `DVF_CTRL_OFS, 32'h0400_0000);
    wb(0, `DVF_STAT_OFS, 0); `CHK(q[2:1], 2'b00)
    wb(0, `DVF_CTRL_OFS, 0); `CHK(q, 32'h0)
    wb(1, `DVF_CTRL_OFS, 32'h0100_0000); push_rx(32'h2222_0004);
    wb(0, `DVF_RXFIFO_OFS, 0); `CHK(q, 32'h0)
    app_u.read_word(0, got, rd); `CHK({got, rd}, {1'b1, 32'h2222_0004})
    wb(1, `DVF_CTRL_OFS, 32'h0100_0400); push_rx(32'h3333_0005);
    app_u.read_word(0, got, rd); `CHK(got, 1'b0)
    app_u.read_word(1, got, rd); `CHK({got, rd}, {1'b1, 32'h3333_0005})
    wb(1, `DVF_CTRL_OFS, 32'h1000_0000); push_rx(32'h4444_0006);
    wb(0, `DVF_STAT_OFS, 0); `CHK({vsm, q[2:1]}, 3'b100)
    wb(1, `DVF_CTRL_OFS, 0); app_u.write_word(32'h5555_0007);
    wb(1, `DVF_TXFIFO_OFS, 32'h5555_0008); repeat (2) @(posedge clk_i);
    `CHK({txv, txd}, {1'b1, 32'h5555_0008})
    tx_ready <= 1'b1; @(posedge clk_i); tx_ready <= 1'b0;
    wb(1, `DVF_TXFIFO_OFS, 32'h5555_0009); wb(1, `DVF_CTRL_OFS, 32'h0800_0000);
    wb(0, `DVF_STAT_OFS, 0); `CHK(q[4:3], 2'b00)
    `CHK(txv, 1'b0)
    wb(1, `DVF_CTRL_OFS, 32'h0200_0000); wb(1, `DVF_TXFIFO_OFS, 32'h6666_000a);
    app_u.write_word(32'h6666_000b); repeat (2) @(posedge clk_i);
    `CHK({txv, txd}, {1'b1, 32'h6666_000b})
    conclude();
  end
endmodule
